// file: core/dnl_cfg_if.sv
interface dnl_cfg_if;
  logic [3:0] frame_format_select;
  logic [2:0] serial_rate_select;
  logic [7:0] station_address;
  logic       latched;
  modport src
  (
    output frame_format_select,
    output serial_rate_select,
    output station_address,
    output latched
  );
  modport dst
  (
    input frame_format_select,
    input serial_rate_select,
    input station_address,
    input latched
  );
endinterface

// file: core/dnl_cfg_latch.sv
`include "dnl_consts.svh"
module dnl_cfg_latch
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Settings as stored, possibly changed since power-up
  input  wire logic [3:0] fmt_i,
  input  wire logic [2:0] rate_i,
  input  wire logic [7:0] addr_i,
  // Values captured at power-up
  dnl_cfg_if.src          cfg
);
  import dnl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Capture once after reset release, hold until next power cycle
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg.latched             <= 1'b0;
      cfg.frame_format_select <= `DNL_FMT_DEF;
      cfg.serial_rate_select  <= `DNL_RATE_DEF;
      cfg.station_address     <= `DNL_ADDR_DEF;
    end
    else if (!cfg.latched)
    begin
      cfg.latched <= 1'b1;
      cfg.frame_format_select <= (fmt_i > `DNL_FMT_MAX) ? `DNL_FMT_DEF : fmt_i;
      cfg.serial_rate_select <=
        (rate_i > `DNL_RATE_MAX) ? `DNL_RATE_DEF : rate_i;
      cfg.station_address <=
        (addr_i < `DNL_ADDR_MIN || addr_i > `DNL_ADDR_MAX)
          ? `DNL_ADDR_DEF : addr_i;
    end
  end
endmodule

// file: core/dnl_consts.svh
`ifndef DNL_CONSTS_SVH
`define DNL_CONSTS_SVH
// Clock and time base
`define DNL_CLK_HZ          100000000
`define DNL_TICK_MS         100
`define DNL_TICK_CYC        (`DNL_CLK_HZ / 1000 * `DNL_TICK_MS)
`define DNL_START_MS        10
`define DNL_START_CYC       (`DNL_CLK_HZ / 1000 * `DNL_START_MS)
// Setting limits and defaults
`define DNL_FMT_MAX         4'h9
`define DNL_FMT_DEF         4'h0
`define DNL_RATE_MAX        3'h5
`define DNL_RATE_DEF        3'h3
`define DNL_ADDR_MIN        8'h01
`define DNL_ADDR_MAX        8'hF7
`define DNL_ADDR_DEF        8'h64
`define DNL_DLY_MIN         10'h001
`define DNL_DLY_MAX         10'h258
`define DNL_DLY_DEF         10'h032
`define DNL_RESP_MAX        3'h5
`define DNL_SCHEME_MAX      3'h6
`define DNL_SCHEME_DEF      3'h3
`define DNL_FAULT_CODE      8'h51
`endif

// file: core/dnl_loss_timer.sv
`include "dnl_consts.svh"
module dnl_loss_timer
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Link condition
  input  wire logic       loss_cond_i,
  input  wire logic       frame_ok_i,
  input  wire logic [9:0] delay_i,
  // Delay elapsed
  output logic            expired_o
);
  import dnl_pkg::*;

  logic [23:0] tick_cnt;
  logic [9:0]  tenth_cnt;
  logic [9:0]  delay_eff;

  // Out-of-range delay falls back to the default
  assign delay_eff = (delay_i < `DNL_DLY_MIN || delay_i > `DNL_DLY_MAX)
                     ? `DNL_DLY_DEF : delay_i;

  ////////////////////////////////////////////////////////////////////////////
  // Tenth-second prescaler, restarted by a valid frame
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      tick_cnt <= 24'h00_0000;
    else if (frame_ok_i || !loss_cond_i || expired_o)
      tick_cnt <= 24'h00_0000;
    else if (tick_cnt == 24'(`DNL_TICK_CYC - 1))
      tick_cnt <= 24'h00_0000;
    else
      tick_cnt <= tick_cnt + 24'h00_0001;
  end

  // Tenth counter and expiry flag
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tenth_cnt <= 10'h000;
      expired_o <= 1'b0;
    end
    else if (frame_ok_i || !loss_cond_i)
    begin
      tenth_cnt <= 10'h000;
      expired_o <= 1'b0;
    end
    else if (!expired_o && tick_cnt == 24'(`DNL_TICK_CYC - 1))
    begin
      tenth_cnt <= tenth_cnt + 10'h001;
      if (tenth_cnt + 10'h001 >= delay_eff)
        expired_o <= 1'b1;
    end
  end
endmodule

// file: core/dnl_pkg.sv
package dnl_pkg;
  // Frame parity
  typedef enum logic [1:0]
  {
    DNL_PAR_NONE = 2'b00,
    DNL_PAR_EVEN = 2'b01,
    DNL_PAR_ODD  = 2'b10
  } dnl_parity_type;
  // Protocol family
  typedef enum logic [1:0]
  {
    DNL_PROTO_RTU  = 2'b00,
    DNL_PROTO_BAS  = 2'b01,
    DNL_PROTO_FLOOR = 2'b10
  } dnl_proto_type;
  // Link-loss responses
  typedef enum logic [2:0]
  {
    DNL_RESP_FAULT  = 3'b000,
    DNL_RESP_COAST  = 3'b001,
    DNL_RESP_STOP   = 3'b010,
    DNL_RESP_LAST   = 3'b011,
    DNL_RESP_PRESET = 3'b100,
    DNL_RESP_KEYPAD = 3'b101
  } dnl_resp_type;
  // Speed source while the link is lost
  typedef enum logic [1:0]
  {
    DNL_SPD_NET    = 2'b00,
    DNL_SPD_PRESET = 2'b01,
    DNL_SPD_KEYPAD = 2'b10
  } dnl_speed_type;
  // Run state of the start scheme
  typedef enum logic [1:0]
  {
    DNL_RUN_IDLE  = 2'b00,
    DNL_RUN_ARMED = 2'b01,
    DNL_RUN_FORWARD_INPUT   = 2'b10,
    DNL_RUN_REVERSE_INPUT   = 2'b11
  } dnl_run_type;
endpackage

// file: core/dnl_supervisor.sv
`include "dnl_consts.svh"
module dnl_supervisor
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  // Stored settings
  input  wire logic [3:0]             frame_format_select_i,
  input  wire logic [2:0]             serial_rate_select_i,
  input  wire logic [7:0]             station_address_i,
  input  wire logic [2:0]             link_loss_response_i,
  input  wire logic [9:0]             link_loss_delay_i,
  input  wire logic                   store_mode_select_i,
  input  wire logic [2:0]             alternate_start_scheme_i,
  // Link events from the receiver
  input  wire logic                   frame_valid_i,
  input  wire logic [7:0]             frame_addr_i,
  input  wire logic                   link_connected_i,
  input  wire logic                   error_excess_i,
  input  wire logic                   param_write_i,
  // Control source
  input  wire logic                   net_control_i,
  input  wire logic                   net_local_run_i,
  input  wire logic                   fault_clear_i,
  // Terminal pins
  input  wire logic                   term1_i,
  input  wire logic                   term2_i,
  input  wire logic                   term3_i,
  // Frame format
  output logic [1:0]                  stop_bits_o,
  output dnl_pkg::dnl_parity_type     parity_o,
  output dnl_pkg::dnl_proto_type      proto_o,
  output logic [17:0]                 baud_rate_o,
  output logic [7:0]                  active_address_o,
  output logic                        addr_match_o,
  // Link loss
  output logic                        link_loss_o,
  output logic                        link_loss_fault_o,
  output logic [7:0]                  fault_code_o,
  output dnl_pkg::dnl_speed_type      loss_speed_src_o,
  output logic                        loss_speed_hold_o,
  // Parameter write routing
  output logic                        nonvolatile_store_o,
  output logic                        ram_store_o,
  // Motor command
  output logic                        run_o,
  output logic                        reverse_o,
  output logic                        coast_stop_o,
  output logic                        ramp_stop_o,
  output logic                        ready_to_run_o,
  output logic                        function_loss_fault_o
);
  import dnl_pkg::*;

  dnl_cfg_if cfg ();
  logic        s1_t1, s1_t2, s1_t3, s1_con, s1_err;
  logic        t1, t2, t3, con, err;
  logic        t2_prev, t3_prev;
  logic        loss_cond;
  logic        frame_ok;
  logic        expired;
  logic        loss_active;
  logic [2:0]  resp;
  logic [2:0]  scheme;
  logic        alt_active;
  logic        level_mode;
  logic        t2_rise, t3_rise;
  logic        start_req;
  logic        stop_req;
  logic        coast_req;
  logic        loss_stop;
  logic        loss_coast;
  logic        func_loss;
  dnl_run_type run_state;
  dnl_run_type next_run_state;
  logic [19:0] start_cnt;
  logic        fault_hold;

  // Baud figure for a rate code
  function automatic logic [17:0] rate_baud(input logic [2:0] code);
    case (code)
      3'h0:    rate_baud = 18'h0_04B0;
      3'h1:    rate_baud = 18'h0_0960;
      3'h2:    rate_baud = 18'h0_12C0;
      3'h3:    rate_baud = 18'h0_2580;
      3'h4:    rate_baud = 18'h0_4B00;
      3'h5:    rate_baud = 18'h0_9600;
      default: rate_baud = 18'h0_2580;
    endcase
  endfunction

  // Parity for a format code
  function automatic dnl_parity_type fmt_parity(input logic [3:0] code);
    case (code)
      4'h1, 4'h4, 4'h8: fmt_parity = DNL_PAR_EVEN;
      4'h2, 4'h5, 4'h9: fmt_parity = DNL_PAR_ODD;
      default:          fmt_parity = DNL_PAR_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Power-up capture of link settings
  dnl_cfg_latch u_latch
  (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .fmt_i  (frame_format_select_i),
    .rate_i (serial_rate_select_i),
    .addr_i (station_address_i),
    .cfg    (cfg.src)
  );

  // Frame format decode
  always_comb
  begin
    parity_o    = fmt_parity(cfg.frame_format_select);
    stop_bits_o = 2'h1;
    proto_o     = DNL_PROTO_RTU;
    if (cfg.frame_format_select >= 4'h3 && cfg.frame_format_select <= 4'h5)
      stop_bits_o = 2'h2;
    if (cfg.frame_format_select == 4'h6)
      proto_o = DNL_PROTO_BAS;
    else if (cfg.frame_format_select >= 4'h7)
      proto_o = DNL_PROTO_FLOOR;
  end

  assign baud_rate_o      = rate_baud(cfg.serial_rate_select);
  assign active_address_o = cfg.station_address;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      {s1_t1, s1_t2, s1_t3, s1_con, s1_err} <= 5'h00;
      {t1, t2, t3, con, err}                <= 5'h00;
    end
    else
    begin
      {s1_t1, s1_t2, s1_t3, s1_con, s1_err} <=
        {term1_i, term2_i, term3_i, link_connected_i, error_excess_i};
      {t1, t2, t3, con, err} <= {s1_t1, s1_t2, s1_t3, s1_con, s1_err};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address match and loss detection
  assign addr_match_o = frame_valid_i &&
                        frame_addr_i == cfg.station_address;
  assign frame_ok     = addr_match_o && cfg.latched;
  assign loss_cond    = !con || err;

  dnl_loss_timer u_timer
  (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .loss_cond_i (loss_cond),
    .frame_ok_i  (frame_ok),
    .delay_i     (link_loss_delay_i),
    .expired_o   (expired)
  );

  // Response sampled when the delay ends, held for the episode
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      loss_active <= 1'b0;
      resp        <= 3'h0;
    end
    else if (!expired)
      loss_active <= 1'b0;
    else if (!loss_active)
    begin
      loss_active <= 1'b1;
      resp <= (link_loss_response_i > `DNL_RESP_MAX)
              ? 3'h0 : link_loss_response_i;
    end
  end

  assign link_loss_o = loss_active;

  // Response decode
  always_comb
  begin
    loss_coast        = 1'b0;
    loss_stop         = 1'b0;
    loss_speed_hold_o = 1'b0;
    loss_speed_src_o  = DNL_SPD_NET;
    if (loss_active)
    begin
      case (resp)
        3'h0:    loss_coast = 1'b1;
        3'h1:    loss_coast = 1'b1;
        3'h2:    loss_stop  = 1'b1;
        3'h3:    loss_speed_hold_o = 1'b1;
        3'h4:
        begin
          loss_speed_hold_o = 1'b1;
          loss_speed_src_o  = DNL_SPD_PRESET;
        end
        3'h5:
        begin
          loss_speed_hold_o = 1'b1;
          loss_speed_src_o  = DNL_SPD_KEYPAD;
        end
        default: loss_coast = 1'b1;
      endcase
    end
  end

  // Faults latch until cleared; a new cause wins over the clear
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      link_loss_fault_o     <= 1'b0;
      function_loss_fault_o <= 1'b0;
    end
    else
    begin
      if (loss_active && resp == 3'h0)
        link_loss_fault_o <= 1'b1;
      else if (fault_clear_i)
        link_loss_fault_o <= 1'b0;
      if (func_loss)
        function_loss_fault_o <= 1'b1;
      else if (fault_clear_i)
        function_loss_fault_o <= 1'b0;
    end
  end

  assign fault_hold   = link_loss_fault_o || function_loss_fault_o;
  assign fault_code_o = link_loss_fault_o ? `DNL_FAULT_CODE : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Network write routing
  assign nonvolatile_store_o = param_write_i && !store_mode_select_i;
  assign ram_store_o         = param_write_i && store_mode_select_i;

  ////////////////////////////////////////////////////////////////////////////
  // Alternate start scheme decode
  assign scheme = (alternate_start_scheme_i > `DNL_SCHEME_MAX)
                  ? `DNL_SCHEME_DEF : alternate_start_scheme_i;
  assign alt_active = net_control_i && net_local_run_i;
  assign level_mode = scheme == 3'h3 || scheme == 3'h6;
  assign t2_rise    = t2 && !t2_prev;
  assign t3_rise    = t3 && !t3_prev;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      {t2_prev, t3_prev} <= 2'b11;
    else
      {t2_prev, t3_prev} <= {t2, t3};
  end

  // Terminal roles per scheme
  always_comb
  begin
    coast_req = 1'b0;
    stop_req  = 1'b0;
    start_req = 1'b0;
    func_loss = 1'b0;
    if (alt_active)
    begin
      case (scheme)
        3'h0, 3'h5: coast_req = !t1;
        3'h1:
        begin
          stop_req  = !t1;
          start_req = t2_rise;
        end
        3'h2, 3'h4:
        begin
          coast_req = !t1;
          start_req = t2_rise || t3_rise;
        end
        3'h3:
        begin
          coast_req = !t1;
          start_req = t2 || t3;
        end
        3'h6:
        begin
          func_loss = !t1;
          coast_req = !t1 || !t3;
          start_req = t2 && t3;
        end
        default: coast_req = 1'b1;
      endcase
    end
  end

  assign coast_stop_o = coast_req || loss_coast || fault_hold;
  assign ramp_stop_o  = stop_req || loss_stop;
  assign ready_to_run_o = alt_active && scheme == 3'h4;

  // Run state machine
  always_comb
  begin
    next_run_state = run_state;
    case (run_state)
      DNL_RUN_IDLE:
        if (!coast_stop_o && !ramp_stop_o && start_req)
          next_run_state = DNL_RUN_ARMED;
      DNL_RUN_ARMED:
        if (coast_stop_o || ramp_stop_o || !alt_active)
          next_run_state = DNL_RUN_IDLE;
        else if (scheme != 3'h4 || start_cnt == 20'h0_0000)
          next_run_state = (scheme == 3'h1 ? t3 : (t3 && !t2 && !level_mode
                            || scheme == 3'h3 && t3 && !t2))
                           ? DNL_RUN_REVERSE_INPUT : DNL_RUN_FORWARD_INPUT;
      DNL_RUN_FORWARD_INPUT, DNL_RUN_REVERSE_INPUT:
        if (coast_stop_o || ramp_stop_o || !alt_active)
          next_run_state = DNL_RUN_IDLE;
        else if (scheme != 3'h1 && !t2 && !t3)
          next_run_state = DNL_RUN_IDLE;
      default: next_run_state = DNL_RUN_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      run_state <= DNL_RUN_IDLE;
    else
      run_state <= next_run_state;
  end

  // Scheme 4 start delay counter, 4 cycles in ARMED before run
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      start_cnt <= 20'h0_0000;
    else if (run_state != DNL_RUN_ARMED)
      start_cnt <= 20'h0_0003;
    else if (start_cnt != 20'h0_0000)
      start_cnt <= start_cnt - 20'h0_0001;
  end

  // Registered motor command
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      run_o     <= 1'b0;
      reverse_o <= 1'b0;
    end
    else
    begin
      run_o     <= next_run_state == DNL_RUN_FORWARD_INPUT ||
                   next_run_state == DNL_RUN_REVERSE_INPUT;
      reverse_o <= next_run_state == DNL_RUN_REVERSE_INPUT;
    end
  end
endmodule

// file: verif/dnl_net_master.sv
module dnl_net_master
(
  // Clock
  input  wire logic       clk_i,
  // Frame and link events towards the device
  output logic            frame_valid_o,
  output logic [7:0]      frame_addr_o,
  output logic            link_connected_o,
  output logic            error_excess_o,
  output logic            param_write_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle link at time zero
  initial
  begin
    frame_valid_o    = 1'b0;
    frame_addr_o     = 8'h00;
    link_connected_o = 1'b1;
    error_excess_o   = 1'b0;
    param_write_o    = 1'b0;
  end
  // Frame start, held until end_frame, optionally carrying a parameter write
  task automatic start_frame(input logic [7:0] a, input logic w);
    @(posedge clk_i);
    frame_valid_o <= 1'b1;
    frame_addr_o  <= a;
    param_write_o <= w;
  endtask
  // Released address bus shows the inverse, not the last value
  task automatic end_frame();
    @(posedge clk_i);
    frame_valid_o <= 1'b0;
    frame_addr_o  <= ~frame_addr_o;
    param_write_o <= 1'b0;
  endtask
  // Link state seen by the device
  task automatic set_link(input logic conn, input logic exc);
    @(posedge clk_i);
    link_connected_o <= conn;
    error_excess_o   <= exc;
  endtask
endmodule

// file: verif/dnl_supervisor_bench.sv
module dnl_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dnl_pkg::*;
  // Design ports
  logic clk_i = 1'b0, nrst_i = 1'b0;
  logic [3:0] frame_format_select_i = 4'h0;
  logic [2:0] serial_rate_select_i = 3'h3, link_loss_response_i = 3'h0;
  logic [2:0] alternate_start_scheme_i = 3'h3;
  logic [7:0] station_address_i = 8'h64, frame_addr_i, active_address_o;
  logic [9:0] link_loss_delay_i = 10'h001;
  logic store_mode_select_i = 1'b0, frame_valid_i, link_connected_i;
  logic error_excess_i, param_write_i, fault_clear_i = 1'b1;
  logic net_control_i = 1'b1, net_local_run_i = 1'b1;
  logic term1_i = 1'b0, term2_i = 1'b0, term3_i = 1'b0;
  logic [1:0] stop_bits_o;
  dnl_parity_type parity_o;
  dnl_proto_type proto_o;
  dnl_speed_type loss_speed_src_o;
  logic [17:0] baud_rate_o;
  logic [7:0] fault_code_o;
  logic addr_match_o, link_loss_o, link_loss_fault_o, loss_speed_hold_o;
  logic nonvolatile_store_o, ram_store_o, run_o, reverse_o, coast_stop_o;
  logic ramp_stop_o, ready_to_run_o, function_loss_fault_o;
  int n_errors = 0, compares = 0;
  logic [31:0] seed = 32'h0000_efe7;
  logic [7:0] cases [8] = '{8'h4e, 8'h57, 8'h1c, 8'hbc, 8'h2e, 8'h6e, 8'h8e,
                            8'hde};
  dnl_supervisor u_dnl_supervisor (.*);
  dnl_net_master u_dnl_net_master (.clk_i, .frame_valid_o(frame_valid_i),
    .frame_addr_o(frame_addr_i), .link_connected_o(link_connected_i),
    .error_excess_o(error_excess_i), .param_write_o(param_write_i));
  ////////////////////////////////////////////////////////////////////////////
  // Clock
  always #5 clk_i = ~clk_i;
  // Xorshift source
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected {stop bits, parity, protocol} for a format code
  function automatic logic [5:0] exp_fmt(input logic [3:0] f);
    logic [3:0] p;
    p = (f < 4'h6) ? f % 4'h3 : f - 4'h7;
    return {(f > 4'h2 && f < 4'h6) ? 2'h2 : 2'h1, p[1:0],
            (f < 4'h6) ? 2'h0 : ((f == 4'h6) ? 2'h1 : 2'h2)};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Comparison and closing report
  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Power cycle with new stored settings
  task automatic por(input logic [3:0] f, input logic [2:0] r,
                     input logic [7:0] a);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    frame_format_select_i <= f;
    serial_rate_select_i <= r;
    station_address_i <= a;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  // Frame settings at the ports
  task automatic cfg_chk(input logic [3:0] f, input logic [2:0] r,
                         input logic [7:0] a);
    check("proto", proto_o, exp_fmt(f) & 6'h03);
    if (f != 4'h6)
      check("format", {stop_bits_o, parity_o, proto_o}, exp_fmt(f));
    check("baud", baud_rate_o, 32'h0000_04b0 << r);
    check("address", active_address_o, a);
  endtask
  // Stop the drive, select a scheme, apply terminals and await the result
  task automatic wait_run(input logic er);
    for (int k = 0; k < 40; k++)
    begin
      @(posedge clk_i);
      #1;
      if (er && run_o === 1'b1)
        break;
    end
    #1;
  endtask
  task automatic apply(input logic [2:0] s, t, input logic er, ev);
    @(posedge clk_i);
    {term3_i, term2_i, term1_i} <= 3'h0;
    repeat (8) @(posedge clk_i);
    alternate_start_scheme_i <= s;
    @(posedge clk_i);
    {term3_i, term2_i, term1_i} <= t;
    wait_run(er);
    check("run", {run_o, reverse_o}, {er, ev});
    if (s == 3'h4)
      check("ready", ready_to_run_o, 1'b1);
    if (er)
      check("no stop", {coast_stop_o, ramp_stop_o}, 2'h0);
  endtask
  // Stop then release with run held
  task automatic edge_test(input logic [2:0] s, input logic er);
    apply(s, 3'h7, 1'b1, 1'b0);
    @(posedge clk_i);
    term1_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    check("coast", coast_stop_o, 1'b1);
    @(posedge clk_i);
    term1_i <= 1'b1;
    wait_run(er);
    check("restart", run_o, er);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    logic [7:0] a;
    for (int i = 0; i < 10; i++)
    begin
      a = 8'h01 + 8'(rnd() % 247);
      por(4'(i), 3'(i % 6), a);
      cfg_chk(4'(i), 3'(i % 6), a);
      @(posedge clk_i);
      frame_format_select_i <= 4'(rnd() % 10);
      serial_rate_select_i <= 3'(rnd() % 6);
      station_address_i <= 8'h01 + 8'(rnd() % 247);
      store_mode_select_i <= 1'(rnd());
      link_loss_response_i <= 3'(rnd() % 6);
      repeat (3) @(posedge clk_i);
      #1;
      cfg_chk(4'(i), 3'(i % 6), a);
      u_dnl_net_master.start_frame(a, 1'b1);
      #1;
      check("match", addr_match_o, 1'b1);
      check("nvs", nonvolatile_store_o, !store_mode_select_i);
      check("ram", ram_store_o, store_mode_select_i);
      u_dnl_net_master.end_frame();
      u_dnl_net_master.start_frame(a ^ 8'(rnd() % 255 + 1), 1'b0);
      #1;
      check("mismatch", addr_match_o, 1'b0);
      u_dnl_net_master.end_frame();
    end
    $display("test settings done");
    u_dnl_net_master.set_link(1'b0, 1'b0);
    repeat (300) @(posedge clk_i);
    u_dnl_net_master.set_link(1'b1, 1'b1);
    repeat (300) @(posedge clk_i);
    #1;
    check("early loss", {link_loss_o, link_loss_fault_o}, 2'h0);
    u_dnl_net_master.set_link(1'b1, 1'b0);
    $display("test loss delay done");
    foreach (cases[j])
      apply(cases[j][7:5], cases[j][4:2], cases[j][1], cases[j][0]);
    @(posedge clk_i);
    term1_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    check("func loss", {function_loss_fault_o, run_o}, 2'h2);
    @(posedge clk_i);
    term1_i <= 1'b1;
    fault_clear_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    check("func held", {function_loss_fault_o, coast_stop_o}, 2'h3);
    @(posedge clk_i);
    fault_clear_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
    check("func clear", function_loss_fault_o, 1'b0);
    edge_test(3'h2, 1'b0);
    edge_test(3'h3, 1'b1);
    edge_test(3'h6, 1'b1);
    @(posedge clk_i);
    net_control_i <= 1'b0;
    apply(3'h2, 3'h3, 1'b0, 1'b0);
    $display("test start schemes done");
    finish_test();
  end
endmodule

// file: verif/dnl_supervisor_checker.sv
module dnl_supervisor_checker
  import dnl_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  // Watched ports
  input  wire logic [1:0]             stop_bits_o,
  input  wire dnl_pkg::dnl_proto_type proto_o,
  input  wire logic [17:0]            baud_rate_o,
  input  wire logic [7:0]             active_address_o,
  input  wire logic                   frame_valid_i,
  input  wire logic [7:0]             frame_addr_i,
  input  wire logic                   addr_match_o,
  input  wire logic                   param_write_i,
  input  wire logic                   store_mode_select_i,
  input  wire logic                   nonvolatile_store_o,
  input  wire logic                   ram_store_o,
  input  wire logic                   link_loss_fault_o,
  input  wire logic [7:0]             fault_code_o,
  input  wire logic                   coast_stop_o,
  input  wire logic                   link_loss_o,
  input  wire logic                   link_connected_i,
  input  wire logic                   error_excess_i,
  input  wire logic                   run_o,
  input  wire logic                   net_control_i,
  input  wire logic                   net_local_run_i,
  input  wire logic                   function_loss_fault_o
);
  import dnl_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Captured settings hold once power-up is past
  AST_CFG_HELD: assert property ($past(nrst_i, 2) |-> $stable(baud_rate_o)
    && $stable(stop_bits_o) && $stable(proto_o) && $stable(active_address_o))
    else $error("frame settings moved after power-up");
  AST_RTU_STOP: assert property (proto_o == DNL_PROTO_RTU |-> stop_bits_o
    inside {2'h1, 2'h2}) else $error("bad stop bit count");
  AST_FLOOR_STOP: assert property (proto_o == DNL_PROTO_FLOOR
    |-> stop_bits_o == 2'h1) else $error("floor protocol stop bits");
  AST_BAUD: assert property (baud_rate_o inside {18'h04b0, 18'h0960,
    18'h12c0, 18'h2580, 18'h4b00, 18'h9600}) else $error("bad baud rate");
  AST_ADDR_MATCH: assert property (addr_match_o |-> frame_valid_i
    && frame_addr_i == active_address_o) else $error("false address match");
  AST_ADDR_RANGE: assert property (active_address_o inside
    {[8'h01:8'hf7]}) else $error("station address out of range");
  AST_STORE: assert property (param_write_i |->
    nonvolatile_store_o == !store_mode_select_i
    && ram_store_o == store_mode_select_i) else $error("write routing");
  AST_FAULT_CODE: assert property (link_loss_fault_o |->
    fault_code_o == 8'h51 && coast_stop_o) else $error("link fault output");
  AST_LOSS_CAUSE: assert property ($rose(link_loss_o) |->
    $past(!link_connected_i || error_excess_i, 3))
    else $error("link loss without cause");
  AST_RUN_SRC: assert property ($rose(run_o) |-> $past(net_control_i)
    && $past(net_local_run_i)) else $error("run outside network local");
  AST_FUNC_LOSS: assert property (function_loss_fault_o |->
    coast_stop_o) else $error("function loss does not coast");
endmodule
bind dnl_supervisor dnl_supervisor_checker u_dnl_supervisor_checker
  (.clk_i, .nrst_i, .stop_bits_o, .proto_o, .baud_rate_o, .active_address_o,
   .frame_valid_i, .frame_addr_i, .addr_match_o, .param_write_i,
   .store_mode_select_i, .nonvolatile_store_o, .ram_store_o,
   .link_loss_fault_o, .fault_code_o, .coast_stop_o, .link_loss_o,
   .link_connected_i, .error_excess_i, .run_o, .net_control_i,
   .net_local_run_i, .function_loss_fault_o);
